// *** pkg/sbt_defines.svh ***
`ifndef SBT_DEFINES_SVH
`define SBT_DEFINES_SVH

// Scan path lengths
`define SBT_IR_W          3
`define SBT_ID_W          32
`define SBT_RING_W        109
`define SBT_PIN_W         108
`define SBT_OE_CELL       108

// Instruction codes
`define SBT_IR_EXTEST     3'h0
`define SBT_IR_IDCODE     3'h1
`define SBT_IR_SAMPLEZ    3'h2
`define SBT_IR_RSVD3      3'h3
`define SBT_IR_SAMPLE     3'h4
`define SBT_IR_RSVD5      3'h5
`define SBT_IR_RSVD6      3'h6
`define SBT_IR_BYPASS     3'h7

// Capture-IR pattern, low two bits 01
`define SBT_IR_CAPTURE    3'h1

// Identification word fields
`define SBT_ID_VER_HI     31
`define SBT_ID_VER_LO     29
`define SBT_ID_PART_HI    28
`define SBT_ID_PART_LO    12
`define SBT_ID_MAKER_HI   11
`define SBT_ID_MAKER_LO   1
`define SBT_ID_PRESENT    1'h1

// Reset values
`define SBT_OE_CELL_RST   1'h1
`define SBT_BYPASS_CAP    1'h0

`endif

// *** pkg/sbt_pkg.sv ***
`default_nettype none
package sbt_pkg;

	// TAP controller states, standard binary encoding
	typedef enum logic [3:0] {
		sbt_exit2_dr      = 4'h0,
		sbt_exit1_dr      = 4'h1,
		sbt_shift_dr      = 4'h2,
		sbt_pause_dr      = 4'h3,
		sbt_select_ir     = 4'h4,
		sbt_update_dr     = 4'h5,
		sbt_capture_dr    = 4'h6,
		sbt_select_dr     = 4'h7,
		sbt_exit2_ir      = 4'h8,
		sbt_exit1_ir      = 4'h9,
		sbt_shift_ir      = 4'ha,
		sbt_pause_ir      = 4'hb,
		sbt_run_idle      = 4'hc,
		sbt_update_ir     = 4'hd,
		sbt_capture_ir    = 4'he,
		sbt_test_reset    = 4'hf
	} sbt_state_t;

	// Output control levels passed to the memory clock domain
	typedef struct packed {
		logic extest;
		logic samplez;
		logic oe_cell;
	} sbt_ctrl_t;

endpackage : sbt_pkg
`default_nettype wire

// *** core/sbt_tap.sv ***
`default_nettype none
`include "sbt_defines.svh"

// Operation
// - TAP state advances each rising test-clock edge on the sampled mode-select level.
// - Instruction 3 bits, skip 1 bit, identification 32 bits, pin ring 109 cells.
// - Code 000 captures the pin ring and puts it in the serial path.
// - Code 001 loads the fixed identification word and shifts it out.
// - Code 010 captures pins, shifts the ring, forces memory outputs to high impedance.
// - Code 100 captures the pin ring and shifts it, memory unaffected.
// - Code 111 puts the single skip bit between serial input and output.
// - Identification bits 31:29 hold version, bits 28:12 hold part type.
// - Identification bits 11:1 carry the maker code.
// - Identification bit 0 is always 1.
// - Serial input shifts on rising edges, serial output changes on falling edges.
// - Capture-IR loads 01 into the two low instruction bits.
// - Reset and Test-Logic-Reset select the identification instruction.
// - Cell 108 enables outputs high, tri-states low under code 000; presets high.
module sbt_tap #(
	parameter logic [2:0]  VERSION   = 3'h2,      // Arbitrary value
	parameter logic [16:0] PART_TYPE = 17'h01234, // Arbitrary value
	parameter logic [10:0] MAKER     = 11'h155    // Arbitrary value
) (
	// Memory clock domain
	input  wire logic                   clock,
	input  wire logic                   rst,
	// Test link
	input  wire logic                   tck,
	input  wire logic                   tms,
	input  wire logic                   tdi,
	output logic                        tdo,
	output logic                        tdo_oe_n,
	// Pin ring and memory output control
	input  wire logic [`SBT_PIN_W-1:0]  pin_ring_in,
	output logic                        q_drive_en,
	output logic                        ring_drive_sel,
	output logic [`SBT_PIN_W-1:0]       ring_drive_value
);

	sbt_pkg::sbt_state_t     state;
	logic [`SBT_IR_W-1:0]    ir;
	logic [`SBT_IR_W-1:0]    ir_shift;
	logic                    skip_bit;
	logic [`SBT_ID_W-1:0]    id_shift;
	logic [`SBT_RING_W-1:0]  ring_shift;
	logic [`SBT_RING_W-1:0]  ring_update;
	logic [`SBT_PIN_W-1:0]   pin_s1;
	logic [`SBT_PIN_W-1:0]   pin_s2;
	logic                    upd_toggle;
	sbt_pkg::sbt_ctrl_t      ctrl_tck;
	sbt_pkg::sbt_ctrl_t      ctrl_s1;
	sbt_pkg::sbt_ctrl_t      ctrl_s2;
	logic                    tog_s1;
	logic                    tog_s2;
	logic                    tog_s3;
	logic [`SBT_ID_W-1:0]    id_word;
	logic                    ring_sel;
	logic                    next_tdo;

	// Next TAP state from current state and mode select
	function automatic sbt_pkg::sbt_state_t tap_next(input sbt_pkg::sbt_state_t s, input logic m);
		case (s)
			sbt_pkg::sbt_test_reset: tap_next = m ? sbt_pkg::sbt_test_reset : sbt_pkg::sbt_run_idle;
			sbt_pkg::sbt_run_idle:   tap_next = m ? sbt_pkg::sbt_select_dr : sbt_pkg::sbt_run_idle;
			sbt_pkg::sbt_select_dr:  tap_next = m ? sbt_pkg::sbt_select_ir : sbt_pkg::sbt_capture_dr;
			sbt_pkg::sbt_capture_dr: tap_next = m ? sbt_pkg::sbt_exit1_dr : sbt_pkg::sbt_shift_dr;
			sbt_pkg::sbt_shift_dr:   tap_next = m ? sbt_pkg::sbt_exit1_dr : sbt_pkg::sbt_shift_dr;
			sbt_pkg::sbt_exit1_dr:   tap_next = m ? sbt_pkg::sbt_update_dr : sbt_pkg::sbt_pause_dr;
			sbt_pkg::sbt_pause_dr:   tap_next = m ? sbt_pkg::sbt_exit2_dr : sbt_pkg::sbt_pause_dr;
			sbt_pkg::sbt_exit2_dr:   tap_next = m ? sbt_pkg::sbt_update_dr : sbt_pkg::sbt_shift_dr;
			sbt_pkg::sbt_update_dr:  tap_next = m ? sbt_pkg::sbt_select_dr : sbt_pkg::sbt_run_idle;
			sbt_pkg::sbt_select_ir:  tap_next = m ? sbt_pkg::sbt_test_reset : sbt_pkg::sbt_capture_ir;
			sbt_pkg::sbt_capture_ir: tap_next = m ? sbt_pkg::sbt_exit1_ir : sbt_pkg::sbt_shift_ir;
			sbt_pkg::sbt_shift_ir:   tap_next = m ? sbt_pkg::sbt_exit1_ir : sbt_pkg::sbt_shift_ir;
			sbt_pkg::sbt_exit1_ir:   tap_next = m ? sbt_pkg::sbt_update_ir : sbt_pkg::sbt_pause_ir;
			sbt_pkg::sbt_pause_ir:   tap_next = m ? sbt_pkg::sbt_exit2_ir : sbt_pkg::sbt_pause_ir;
			sbt_pkg::sbt_exit2_ir:   tap_next = m ? sbt_pkg::sbt_update_ir : sbt_pkg::sbt_shift_ir;
			sbt_pkg::sbt_update_ir:  tap_next = m ? sbt_pkg::sbt_select_dr : sbt_pkg::sbt_run_idle;
			default:                 tap_next = sbt_pkg::sbt_test_reset;
		endcase
	endfunction : tap_next

	// Fixed identification word
	// version and part fields
	assign id_word = {VERSION, PART_TYPE, MAKER, `SBT_ID_PRESENT};

	// Ring is in the path only for codes 000, 010 and 100
	// reserved codes fall back to skip
	assign ring_sel = (ir == `SBT_IR_EXTEST) || (ir == `SBT_IR_SAMPLEZ) || (ir == `SBT_IR_SAMPLE);

	// TAP controller, rising test clock
	// advance on sampled mode select
	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			state <= sbt_pkg::sbt_test_reset;
		end else begin
			state <= tap_next(state, tms);
		end
	end

	// Pin ring sampled into the test domain; values are asynchronous to the test clock
	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
		end else begin
			pin_s1 <= pin_ring_in;
			pin_s2 <= pin_s1;
		end
	end

	// Instruction shift and update
	// capture pattern 01
	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			ir_shift <= `SBT_IR_CAPTURE;
			ir       <= `SBT_IR_IDCODE;
		end else begin
			case (state)
				sbt_pkg::sbt_test_reset: ir <= `SBT_IR_IDCODE;
				sbt_pkg::sbt_capture_ir: ir_shift <= `SBT_IR_CAPTURE;
				sbt_pkg::sbt_shift_ir:   ir_shift <= {tdi, ir_shift[`SBT_IR_W-1:1]};
				sbt_pkg::sbt_update_ir:  ir <= ir_shift;
				default:                 ir <= ir;
			endcase
		end
	end

	// Skip bit
	// single-bit path
	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			skip_bit <= `SBT_BYPASS_CAP;
		end else if (!ring_sel && ir != `SBT_IR_IDCODE) begin
			if (state == sbt_pkg::sbt_capture_dr) begin
				skip_bit <= `SBT_BYPASS_CAP;
			end else if (state == sbt_pkg::sbt_shift_dr) begin
				skip_bit <= tdi;
			end
		end
	end

	// Identification shift
	// load fixed word and shift
	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			id_shift <= '0;
		end else if (ir == `SBT_IR_IDCODE) begin
			if (state == sbt_pkg::sbt_capture_dr) begin
				id_shift <= id_word;
			end else if (state == sbt_pkg::sbt_shift_dr) begin
				id_shift <= {tdi, id_shift[`SBT_ID_W-1:1]};
			end
		end
	end

	// Pin ring shift; MSB faces serial input, LSB serial output
	// ring capture under external test
	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			ring_shift <= '0;
		end else if (ring_sel) begin
			if (state == sbt_pkg::sbt_capture_dr) begin
				ring_shift <= {ring_update[`SBT_OE_CELL], pin_s2};
			end else if (state == sbt_pkg::sbt_shift_dr) begin
				ring_shift <= {tdi, ring_shift[`SBT_RING_W-1:1]};
			end
		end
	end

	// Ring update latches; toggle announces a new word to the memory domain
	// enable cell presets high
	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			ring_update <= {`SBT_OE_CELL_RST, {`SBT_PIN_W{1'b0}}};
			upd_toggle  <= 1'b0;
		end else if (state == sbt_pkg::sbt_test_reset) begin
			ring_update[`SBT_OE_CELL] <= `SBT_OE_CELL_RST;
		end else if (state == sbt_pkg::sbt_update_dr && ring_sel) begin
			ring_update <= ring_shift;
			upd_toggle  <= ~upd_toggle;
		end
	end

	// Output control levels, set on the same edges as the instruction and enable cell;
	// the test clock may stop right after an update, so the levels must not wait for another edge
	// high impedance request
	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			ctrl_tck <= '{extest: 1'b0, samplez: 1'b0, oe_cell: `SBT_OE_CELL_RST};
		end else if (state == sbt_pkg::sbt_test_reset) begin
			ctrl_tck <= '{extest: 1'b0, samplez: 1'b0, oe_cell: `SBT_OE_CELL_RST};
		end else begin
			if (state == sbt_pkg::sbt_update_ir) begin
				ctrl_tck.extest  <= (ir_shift == `SBT_IR_EXTEST);
				ctrl_tck.samplez <= (ir_shift == `SBT_IR_SAMPLEZ);
			end
			if (state == sbt_pkg::sbt_update_dr && ring_sel) begin
				ctrl_tck.oe_cell <= ring_shift[`SBT_OE_CELL];
			end
		end
	end

	// Serial output source for the current state
	always_comb begin
		next_tdo = 1'b0;
		if (state == sbt_pkg::sbt_shift_ir) begin
			next_tdo = ir_shift[0];
		end else if (ring_sel) begin
			next_tdo = ring_shift[0];
		end else if (ir == `SBT_IR_IDCODE) begin
			next_tdo = id_shift[0];
		end else begin
			next_tdo = skip_bit;
		end
	end

	// Serial output on falling edge; driven only while shifting
	// output changes on falling edge
	always_ff @(negedge tck or posedge rst) begin
		if (rst) begin
			tdo      <= 1'b0;
			tdo_oe_n <= 1'b1;
		end else begin
			tdo      <= next_tdo;
			tdo_oe_n <= !(state == sbt_pkg::sbt_shift_ir || state == sbt_pkg::sbt_shift_dr);
		end
	end

	// Two-flop crossing of control levels and update toggle into the memory domain
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ctrl_s1 <= '{extest: 1'b0, samplez: 1'b0, oe_cell: `SBT_OE_CELL_RST};
			ctrl_s2 <= '{extest: 1'b0, samplez: 1'b0, oe_cell: `SBT_OE_CELL_RST};
			tog_s1  <= 1'b0;
			tog_s2  <= 1'b0;
			tog_s3  <= 1'b0;
		end else begin
			ctrl_s1 <= ctrl_tck;
			ctrl_s2 <= ctrl_s1;
			tog_s1  <= upd_toggle;
			tog_s2  <= tog_s1;
			tog_s3  <= tog_s2;
		end
	end

	// Drive word copied on toggle edge; update word holds for several test clocks, so it is stable here
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ring_drive_value <= '0;
		end else if (tog_s2 != tog_s3) begin
			ring_drive_value <= ring_update[`SBT_PIN_W-1:0];
		end
	end

	// Memory output enables
	// force high impedance
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			q_drive_en     <= 1'b1;
			ring_drive_sel <= 1'b0;
		end else begin
			q_drive_en     <= !ctrl_s2.samplez && !(ctrl_s2.extest && !ctrl_s2.oe_cell);
			ring_drive_sel <= ctrl_s2.extest;
		end
	end

	// Checks on the test domain
	property p_reset_walk;
		@(posedge tck) disable iff (rst) tms [*5] |=> state == sbt_pkg::sbt_test_reset;
	endproperty
	a_reset_walk: assert property (p_reset_walk) else $error("five high mode selects did not reset");

	property p_capture_shift;
		@(posedge tck) disable iff (rst)
			(state == sbt_pkg::sbt_capture_dr && !tms) |=> state == sbt_pkg::sbt_shift_dr ##1
			state == ($past(tms) ? sbt_pkg::sbt_exit1_dr : sbt_pkg::sbt_shift_dr);
	endproperty
	a_capture_shift: assert property (p_capture_shift) else $error("capture did not lead to shift");

	property p_ir_capture;
		@(posedge tck) disable iff (rst) state == sbt_pkg::sbt_capture_ir |=> ir_shift[1:0] == 2'h1;
	endproperty
	a_ir_capture: assert property (p_ir_capture) else $error("capture pattern missing");

	property p_ir_reset;
		@(posedge tck) disable iff (rst) state == sbt_pkg::sbt_test_reset |=> ir == `SBT_IR_IDCODE;
	endproperty
	a_ir_reset: assert property (p_ir_reset) else $error("reset did not select identification");

	property p_id_load;
		@(posedge tck) disable iff (rst)
			(state == sbt_pkg::sbt_capture_dr && ir == `SBT_IR_IDCODE) |=>
			id_shift[`SBT_ID_VER_HI:`SBT_ID_VER_LO] == VERSION &&
			id_shift[`SBT_ID_PART_HI:`SBT_ID_PART_LO] == PART_TYPE &&
			id_shift[`SBT_ID_MAKER_HI:0] == {MAKER, `SBT_ID_PRESENT};
	endproperty
	a_id_load: assert property (p_id_load) else $error("identification word wrong");

	property p_skip_shift;
		@(posedge tck) disable iff (rst)
			(state == sbt_pkg::sbt_shift_dr && ir == `SBT_IR_BYPASS) |=> skip_bit == $past(tdi);
	endproperty
	a_skip_shift: assert property (p_skip_shift) else $error("skip bit did not take input");

	property p_ring_capture;
		@(posedge tck) disable iff (rst)
			(state == sbt_pkg::sbt_capture_dr && (ir == `SBT_IR_SAMPLE || ir == `SBT_IR_EXTEST)) |=>
			ring_shift[`SBT_PIN_W-1:0] == $past(pin_s2);
	endproperty
	a_ring_capture: assert property (p_ring_capture) else $error("pin ring not captured");

	property p_ring_shift_in;
		@(posedge tck) disable iff (rst)
			(state == sbt_pkg::sbt_shift_dr && ir == `SBT_IR_EXTEST) |=> ring_shift[`SBT_OE_CELL] == $past(tdi);
	endproperty
	a_ring_shift_in: assert property (p_ring_shift_in) else $error("ring did not shift input");

	property p_oe_preset;
		@(posedge tck) disable iff (rst) state == sbt_pkg::sbt_test_reset |=> ring_update[`SBT_OE_CELL];
	endproperty
	a_oe_preset: assert property (p_oe_preset) else $error("enable cell not preset");

	property p_tdo_quiet;
		@(negedge tck) disable iff (rst)
			!(state == sbt_pkg::sbt_shift_ir || state == sbt_pkg::sbt_shift_dr) |=> tdo_oe_n;
	endproperty
	a_tdo_quiet: assert property (p_tdo_quiet) else $error("serial output driven outside shift");

	// Check on the memory domain
	property p_samplez_hiz;
		@(posedge clock) disable iff (rst) ctrl_s2.samplez |=> !q_drive_en;
	endproperty
	a_samplez_hiz: assert property (p_samplez_hiz) else $error("outputs not forced off");

	// Main scenarios
	c_bypass_shift: cover property (@(posedge tck) disable iff (rst)
		state == sbt_pkg::sbt_shift_dr && ir == `SBT_IR_BYPASS);
	c_update_ir: cover property (@(posedge tck) disable iff (rst) state == sbt_pkg::sbt_update_ir);
	c_extest_off: cover property (@(posedge clock) disable iff (rst) ring_drive_sel && !q_drive_en);
	c_id_shift: cover property (@(posedge tck) disable iff (rst)
		state == sbt_pkg::sbt_shift_dr && ir == `SBT_IR_IDCODE);

endmodule : sbt_tap
`default_nettype wire

// *** tb/sbt_ctl_model.sv ***
`default_nettype none
// Board-side scan controller; the test clock stands still between scans
module sbt_ctl_model (
	// Test link
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	input  wire logic tdo,
	input  wire logic tdo_oe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HALF = 3;
	logic oe_bad;
	// Idle levels before the first scan
	initial begin
		tck = 1'h0;
		tms = 1'h1;
		tdi = 1'h0;
		oe_bad = 1'h0;
	end
	// mode/data set while low, output and enable taken just before the rise
	task automatic step(input logic m, input logic d, output logic o, output logic e);
		tms = m;
		tdi = d;
		#HALF;
		o = tdo;
		e = tdo_oe_n;
		tck = 1'h1;
		#HALF;
		tck = 1'h0;
	endtask : step
	// Outside shifting the data line toggles, so a stale value never looks valid
	task automatic idle_step(input logic m);
		logic o;
		logic e;
		step(m, ~tdi, o, e);
	endtask : idle_step
	// five high mode levels reach reset from any state
	task automatic tlr();
		repeat (5) idle_step(1'h1);
		idle_step(1'h0);
	endtask : tlr
	// only documented codes are handed in by the bench
	task automatic scan(input logic ir, input int n, input logic [108:0] din, output logic [108:0] dout);
		logic o;
		logic e;
		dout = '0;
		idle_step(1'h1);
		if (ir) idle_step(1'h1);
		idle_step(1'h0);
		idle_step(1'h0);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], o, e);
			dout[i] = o;
			if (e !== 1'h0) oe_bad = 1'h1;
		end
		idle_step(1'h1);
		idle_step(1'h0);
	endtask : scan
endmodule : sbt_ctl_model
`default_nettype wire

// *** tb/sbt_tap_tb.sv ***
`default_nettype none
module sbt_tap_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [2:0]   VER   = 3'h5;      // Arbitrary value
	localparam logic [16:0]  PART  = 17'h0b5e1; // Arbitrary value
	localparam logic [10:0]  MAKER = 11'h2a7;   // Arbitrary value
	localparam logic [107:0] PAT   = {9{12'h5c3}};
	localparam logic [107:0] PRE   = {9{12'ha96}};
	// Inverted at its own width, so the unused top bit of a compare stays zero
	localparam logic [107:0] NPRE  = ~PRE;
	logic         clock;
	logic         rst;
	logic         tck;
	logic         tms;
	logic         tdi;
	logic         tdo;
	logic         tdo_oe_n;
	logic [107:0] pin_ring_in;
	logic         q_drive_en;
	logic         ring_drive_sel;
	logic [107:0] ring_drive_value;
	int           fail_count;
	int           tests_run;
	int           cycles;
	logic [108:0] o;

	sbt_tap #(.VERSION(VER), .PART_TYPE(PART), .MAKER(MAKER)) dut (
		.clock(clock), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
		.pin_ring_in(pin_ring_in), .q_drive_en(q_drive_en), .ring_drive_sel(ring_drive_sel),
		.ring_drive_value(ring_drive_value));
	sbt_ctl_model ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n));

	// 250 MHz memory clock
	always #2 clock = ~clock;
	// Hang guard, well above the roughly 800 cycles the scans need
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			end_of_test();
		end
	end
	task automatic check(input logic [108:0] got, input logic [108:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	// Control levels cross three clock flops after the link update
	task automatic settle();
		repeat (10) @(posedge clock);
	endtask : settle
	task automatic load_ir(input logic [2:0] code);
		ctl.scan(1'h1, 3, {106'h0, code}, o);
		check(o[1:0], 2'h1);
	endtask : load_ir
	task automatic t_idcode();
		ctl.scan(1'h0, 32, '0, o);
		check(o[31:0], {VER, PART, MAKER, 1'h1});
		check(o[0], 1'h1);
		check(tdo_oe_n, 1'h1);
		check(q_drive_en, 1'h1);
		$display("done idcode");
	endtask : t_idcode
	task automatic t_bypass();
		load_ir(3'h7);
		ctl.scan(1'h0, 4, 109'hb, o);
		check(o[3:0], 4'h6);
		$display("done bypass");
	endtask : t_bypass
	task automatic t_sample();
		@(posedge clock);
		#1 pin_ring_in = PAT;
		load_ir(3'h4);
		ctl.scan(1'h0, 109, {1'h0, PRE}, o);
		check(o[107:0], PAT);
		check(o[108], 1'h1);
		settle();
		check(ring_drive_sel, 1'h0);
		check(q_drive_en, 1'h1);
		$display("done sample");
	endtask : t_sample
	task automatic t_extest();
		load_ir(3'h0);
		settle();
		check(ring_drive_sel, 1'h1);
		check(ring_drive_value, PRE);
		check(q_drive_en, 1'h0);
		ctl.scan(1'h0, 109, {1'h1, NPRE}, o);
		check(o[107:0], PAT);
		settle();
		check(ring_drive_value, NPRE);
		check(q_drive_en, 1'h1);
		$display("done extest");
	endtask : t_extest
	task automatic t_samplez();
		load_ir(3'h2);
		settle();
		check(q_drive_en, 1'h0);
		check(ring_drive_sel, 1'h0);
		ctl.scan(1'h0, 109, {1'h0, PRE}, o);
		check(o[107:0], PAT);
		$display("done samplez");
	endtask : t_samplez
	// Cell 108 was left low above, so only the reset preset can enable the outputs here
	task automatic t_reset();
		ctl.tlr();
		load_ir(3'h0);
		settle();
		check(q_drive_en, 1'h1);
		ctl.tlr();
		settle();
		check(ring_drive_sel, 1'h0);
		t_idcode();
		check(ctl.oe_bad, 1'h0);
		$display("done reset");
	endtask : t_reset
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_of_test
	// Main sequence
	initial begin
		clock = 1'h0;
		rst = 1'h1;
		pin_ring_in = '0;
		fail_count = 0;
		tests_run = 0;
		cycles = 0;
		repeat (5) @(posedge clock);
		#1 rst = 1'h0;
		ctl.tlr();
		t_idcode();
		t_bypass();
		t_sample();
		t_extest();
		t_samplez();
		t_reset();
		end_of_test();
	end
endmodule : sbt_tap_tb
`default_nettype wire
